// [verilog/vemtc_device.sv]
// encoder mode and first timing control bank with its small datapath
// assumes synchronous inputs on clk (27 MHz pixel clock) and a host on the link
//
// Overview of operation
// - luma level bit: 0 legacy, 1 SMPTE
// - uv field: 01 700mV, 10 1000mV, 00 default
// - clamp shifted 0..3 clocks, direction bit advances
// - clamp position: 1 back porch, 0 front
// - power-up sleep: pins high start sleeping
// - host keeps pll bit 0 in 4x; toggle resets pll
// - host writes zeros to reserved bits 2..4
// - field count 0..3 ntsc, 0..7 pal
// - luma saturation clips at scaled 255 level
// - sharpness acts only with extended luma filter
// - shared pin: direction and clamp/vsync select
// - progressive inputs; host forbids with 16-bit
// - port width 8, 10, 16 or 20 bits
// - double buffering, not in master mode
// - gamma enable and curve a/b select
// - undershoot limit in 4x while rgb_no_sync low, else min luma
// - black burst replaces luma or y dac
// - chroma delayed up to eight clocks
// - blank input select, pin high disables it
// - luma delayed up to six clocks
// - min luma 7 IRE below blank or sync
// - low-high-low timing reset clears counters
// - main sleep bit works after power-up bit set
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module vemtc_device
  import vemtc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register link
  vemtc_if.dev link,
  // pins and mode inputs
  input wire logic genlock_control_pin,
  input wire logic standard_select_pin,
  input wire logic blank_pin,
  input wire logic oversample_select_bit,
  input wire logic main_sleep_bit,
  input wire logic rgb_no_sync,
  input wire logic luma_filter_extended,
  input wire logic field_start,
  // shared clamp/vsync/teletext pin
  input wire logic shared_pin_in,
  output logic shared_pin_out,
  output logic shared_pin_oe,
  output logic teletext_input,
  // timing pulses in
  input wire logic clamp_front_in,
  input wire logic clamp_back_in,
  input wire logic vertical_sync_out,
  // video datapath
  input wire logic [9:0] luma_in,
  input wire logic [9:0] chroma_in,
  output logic [9:0] luma_out,
  output logic [9:0] chroma_out,
  // decoded controls
  output logic y_level_smpte,
  output logic [10:0] uv_peak_mv,
  output logic rgb_sync_en,
  output logic sleep,
  output logic pll_en,
  output logic pll_reset,
  output logic [2:0] field_count,
  output logic timing_counter_clear,
  output logic [3:0] color_enables,
  output logic sharpness_active,
  output logic hsync_composite_sel,
  output logic progressive_en,
  output logic [4:0] port_width_bits,
  output logic double_buffer_active,
  output logic noise_reduction_en,
  output logic gamma_en,
  output logic gamma_curve_b,
  output logic black_burst_luma,
  output logic black_burst_y,
  output logic master_mode,
  output logic [1:0] timing_mode,
  output logic blank_external
);
  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [7:0] olc_reg, ppf_reg, cpf_reg, ipp_reg, lbd_reg, tcf_reg;
  logic [7:0] rdata_reg;
  logic pll_prev_reg, treset_prev_reg;
  logic [2:0] field_reg;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      olc_reg <= REG_RESET;
      ppf_reg <= REG_RESET;
      cpf_reg <= REG_RESET;
      ipp_reg <= REG_RESET;
      lbd_reg <= REG_RESET;
      tcf_reg <= REG_RESET;
    end
    else if (link.wr)
    begin
      unique case (link.addr)
        OFF_OUTPUT_LEVEL_CLAMP_CONTROL: olc_reg <= link.wdata;
        OFF_POWER_PLL_FIELD_COUNT: ppf_reg <= link.wdata;
        OFF_COLOR_PIN_FUNCTION_CONTROL: cpf_reg <= link.wdata;
        OFF_INPUT_PORT_PROCESSING_CONTROL: ipp_reg <= link.wdata;
        OFF_LIMITER_BURST_DELAY_CONTROL: lbd_reg <= link.wdata;
        OFF_TIMING_CONTROL_FIRST: tcf_reg <= link.wdata;
        default: ;
      endcase
    end
  end

  // read data one cycle after rd, field count in bits 7:5
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata_reg <= REG_RESET;
    else if (link.rd)
    begin
      unique case (link.addr)
        OFF_OUTPUT_LEVEL_CLAMP_CONTROL: rdata_reg <= olc_reg;
        OFF_POWER_PLL_FIELD_COUNT: rdata_reg <= {field_reg, ppf_reg[4:0]};
        OFF_COLOR_PIN_FUNCTION_CONTROL: rdata_reg <= cpf_reg;
        OFF_INPUT_PORT_PROCESSING_CONTROL: rdata_reg <= ipp_reg;
        OFF_LIMITER_BURST_DELAY_CONTROL: rdata_reg <= lbd_reg;
        OFF_TIMING_CONTROL_FIRST: rdata_reg <= tcf_reg;
        default: rdata_reg <= REG_RESET;
      endcase
    end
  end
  assign link.rdata = rdata_reg;

  // ----------------------------------------
  // pll, timing reset and field counter
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pll_prev_reg <= 1'b0;
      treset_prev_reg <= 1'b0;
    end
    else
    begin
      pll_prev_reg <= ppf_reg[B_PLL];
      treset_prev_reg <= tcf_reg[B_TRESET];
    end
  end
  assign pll_reset = pll_prev_reg ^ ppf_reg[B_PLL];
  assign pll_en = ~ppf_reg[B_PLL];
  assign timing_counter_clear = treset_prev_reg & ~tcf_reg[B_TRESET];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      field_reg <= 3'h0;
    else if (timing_counter_clear)
      field_reg <= 3'h0;
    else if (field_start)
    begin
      if (field_reg >= (standard_select_pin ? FIELD_MAX_PAL : FIELD_MAX_NTSC))
        field_reg <= 3'h0;
      else
        field_reg <= field_reg + 3'h1;
    end
  end
  assign field_count = field_reg;

  // ----------------------------------------
  // decoded mode controls
  // ----------------------------------------
  // luma level select
  assign y_level_smpte = olc_reg[0];
  always_comb
  begin
    unique case (olc_reg[2:1])
      2'b01: uv_peak_mv = UV_MV_700;
      2'b10: uv_peak_mv = UV_MV_1000;
      default: uv_peak_mv = standard_select_pin ? UV_MV_700 : UV_MV_934;
    endcase
  end
  assign rgb_sync_en = olc_reg[3];
  assign sleep = ppf_reg[B_PUP_SLEEP] ? main_sleep_bit : (genlock_control_pin & standard_select_pin);
  assign color_enables = cpf_reg[3:0];
  assign sharpness_active = cpf_reg[B_SHARP] & luma_filter_extended;
  assign hsync_composite_sel = cpf_reg[5];
  assign progressive_en = ipp_reg[B_PROG];
  always_comb
  begin
    unique case ({ipp_reg[B_WIDE], ipp_reg[B_TEN]})
      2'b00: port_width_bits = 5'h08;
      2'b01: port_width_bits = 5'h0a;
      2'b10: port_width_bits = 5'h10;
      default: port_width_bits = 5'h14;
    endcase
  end
  assign master_mode = tcf_reg[0];
  assign timing_mode = tcf_reg[2:1];
  // no double buffering in master mode
  assign double_buffer_active = ipp_reg[2] & ~tcf_reg[0];
  assign noise_reduction_en = ipp_reg[5];
  assign gamma_en = ipp_reg[6];
  assign gamma_curve_b = ipp_reg[7];
  assign black_burst_luma = lbd_reg[2];
  assign black_burst_y = lbd_reg[3];
  assign blank_external = tcf_reg[3] & ~blank_pin;

  // ----------------------------------------
  // clamp placement and shared pin
  // ----------------------------------------
  logic [6:0] clamp_pipe_reg;
  logic clamp_sel;
  logic [2:0] clamp_tap;
  assign clamp_sel = olc_reg[7] ? clamp_back_in : clamp_front_in;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      clamp_pipe_reg <= 7'h00;
    else
      clamp_pipe_reg <= {clamp_pipe_reg[5:0], clamp_sel};
  end
  // advance or delay around nominal tap
  assign clamp_tap = olc_reg[6] ? 3'(CLAMP_NOMINAL - int'(olc_reg[5:4]))
                                : 3'(CLAMP_NOMINAL + int'(olc_reg[5:4]));
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      shared_pin_out <= 1'b0;
    else
      shared_pin_out <= cpf_reg[7] ? clamp_pipe_reg[clamp_tap] : vertical_sync_out;
  end
  assign shared_pin_oe = cpf_reg[6];
  assign teletext_input = ~cpf_reg[6] & shared_pin_in;

  // ----------------------------------------
  // luma and chroma datapath
  // ----------------------------------------
  logic [9:0] luma_pipe_reg [LUMA_DLY_DEPTH];
  logic [9:0] chroma_pipe_reg [CHROMA_DLY_DEPTH];
  logic [9:0] luma_dly, chroma_dly, luma_floor, luma_clip;
  logic [3:0] chroma_cycles;
  logic [2:0] luma_cycles;

  always_ff @(posedge clk)
  begin
    luma_pipe_reg[0] <= luma_in;
    chroma_pipe_reg[0] <= chroma_in;
    for (int i = 1; i < LUMA_DLY_DEPTH; i++)
      luma_pipe_reg[i] <= luma_pipe_reg[i-1];
    for (int i = 1; i < CHROMA_DLY_DEPTH; i++)
      chroma_pipe_reg[i] <= chroma_pipe_reg[i-1];
  end

  // luma delay 0, 2, 4 or 6
  assign luma_cycles = {tcf_reg[5:4], 1'b0};
  assign luma_dly = (luma_cycles == 3'h0) ? luma_in : luma_pipe_reg[luma_cycles - 3'h1];
  assign chroma_cycles = (lbd_reg[7:5] == 3'h0) ? 4'h0 : {1'b0, lbd_reg[7:5]} + 4'h1;
  assign chroma_dly = (chroma_cycles == 4'h0) ? chroma_in : chroma_pipe_reg[3'(chroma_cycles - 4'h1)];

  always_comb
  begin
    luma_floor = tcf_reg[6] ? LUMA_MIN_7IRE : LUMA_SYNC_BOTTOM;
    if (oversample_select_bit && !rgb_no_sync)
    begin
      unique case (lbd_reg[1:0])
        2'b01: luma_floor = LUMA_US_1P5;
        2'b10: luma_floor = LUMA_US_6;
        2'b11: luma_floor = LUMA_US_11;
        default: luma_floor = LUMA_SYNC_BOTTOM;
      endcase
    end
  end
  assign luma_clip = (cpf_reg[1] && luma_dly > LUMA_SAT_MAX) ? LUMA_SAT_MAX : luma_dly;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      luma_out <= 10'h000;
      chroma_out <= 10'h000;
    end
    else
    begin
      luma_out <= (luma_clip < luma_floor) ? luma_floor : luma_clip;
      chroma_out <= chroma_dly;
    end
  end
endmodule

// [verilog/vemtc_pkg.sv]
// package: register map, field positions, reset values and level codes
// assumes an 8-bit register link with a 5-bit address
package vemtc_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [4:0] OFF_OUTPUT_LEVEL_CLAMP_CONTROL = 5'h05;
  localparam logic [4:0] OFF_POWER_PLL_FIELD_COUNT = 5'h06;
  localparam logic [4:0] OFF_COLOR_PIN_FUNCTION_CONTROL = 5'h07;
  localparam logic [4:0] OFF_INPUT_PORT_PROCESSING_CONTROL = 5'h08;
  localparam logic [4:0] OFF_LIMITER_BURST_DELAY_CONTROL = 5'h09;
  localparam logic [4:0] OFF_TIMING_CONTROL_FIRST = 5'h0a;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int B_PUP_SLEEP = 0;
  localparam int B_PLL = 1;
  localparam logic [7:0] RSVD6_MASK = 8'h1c;
  localparam int B_SHARP = 4;
  localparam int B_PROG = 0;
  localparam int B_WIDE = 3;
  localparam int B_TEN = 4;
  localparam int B_TRESET = 7;
  // ----------------------------------------
  // levels (10-bit luma codes) and amplitudes
  // ----------------------------------------
  localparam logic [9:0] LUMA_SAT_MAX = 10'h3fc;
  localparam logic [9:0] LUMA_SYNC_BOTTOM = 10'h000;
  localparam logic [9:0] LUMA_MIN_7IRE = 10'h0e2;
  localparam logic [9:0] LUMA_US_1P5 = 10'h0ed;
  localparam logic [9:0] LUMA_US_6 = 10'h0e4;
  localparam logic [9:0] LUMA_US_11 = 10'h0da;
  localparam logic [10:0] UV_MV_700 = 11'h2bc;
  localparam logic [10:0] UV_MV_934 = 11'h3a6;
  localparam logic [10:0] UV_MV_1000 = 11'h3e8;
  localparam logic [2:0] FIELD_MAX_NTSC = 3'h3;
  localparam logic [2:0] FIELD_MAX_PAL = 3'h7;
  localparam int CLAMP_NOMINAL = 3;
  localparam int LUMA_DLY_DEPTH = 6;
  localparam int CHROMA_DLY_DEPTH = 8;
  // ----------------------------------------
  // host command port
  // ----------------------------------------
  localparam logic [1:0] HOFF_CMD = 2'h0;
  localparam logic [1:0] HOFF_STATUS = 2'h1;
  localparam logic [1:0] HOFF_CONFIG = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_TRESET = 2'h3;
  typedef enum logic [1:0] {
    VEMTC_IDLE = 2'b00,
    VEMTC_RD_WAIT = 2'b01,
    VEMTC_PULSE_LOW = 2'b10
  } vemtc_host_state_t;
endpackage

// [verilog/vemtc_if.sv]
// interface: register link between host and encoder control bank
// assumes both ends share clk; read data comes one cycle after rd
`timescale 1ns/1ps
interface vemtc_if;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// [verilog/vemtc_host.sv]
// host end: takes software commands and drives the register link
// assumes plain sw port with read data one cycle after sw_rd
`timescale 1ns/1ps
module vemtc_host
  import vemtc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // software port
  input wire logic [1:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata,
  // register link
  vemtc_if.host link
);
  vemtc_host_state_t state_reg;
  logic [1:0] cfg_reg;
  logic [7:0] rd_data_reg, data_fix;
  logic adjusted_reg, cmd_go, rd_take_reg;
  logic [4:0] cmd_addr;
  logic [1:0] cmd_op;

  assign cmd_go = sw_wr && sw_addr == HOFF_CMD && state_reg == VEMTC_IDLE && !rd_take_reg;
  assign cmd_addr = sw_wdata[12:8];
  assign cmd_op = sw_wdata[15:14];

  // ----------------------------------------
  // write data sanitising
  // ----------------------------------------
  always_comb
  begin
    data_fix = sw_wdata[7:0];
    if (cmd_addr == OFF_POWER_PLL_FIELD_COUNT)
      data_fix = data_fix & ~RSVD6_MASK;
    // pll bit zero in 4x oversampling
    if (cmd_addr == OFF_POWER_PLL_FIELD_COUNT && cfg_reg[0])
      data_fix[B_PLL] = 1'b0;
    if (cmd_addr == OFF_COLOR_PIN_FUNCTION_CONTROL && !cfg_reg[1])
      data_fix[B_SHARP] = 1'b0;
    if (cmd_addr == OFF_INPUT_PORT_PROCESSING_CONTROL && data_fix[B_WIDE] && !data_fix[B_TEN])
      data_fix[B_PROG] = 1'b0;
    if (cmd_op == OP_TRESET)
      data_fix[B_TRESET] = 1'b1;
  end

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= VEMTC_IDLE;
      link.addr <= 5'h00;
      link.wdata <= 8'h00;
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      rd_data_reg <= 8'h00;
      adjusted_reg <= 1'b0;
      rd_take_reg <= 1'b0;
    end
    else
    begin
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      unique case (state_reg)
        VEMTC_IDLE:
        begin
          if (cmd_go && cmd_op != 2'b00)
          begin
            link.addr <= (cmd_op == OP_TRESET) ? OFF_TIMING_CONTROL_FIRST : cmd_addr;
            link.wdata <= data_fix;
            adjusted_reg <= (data_fix != sw_wdata[7:0]) && cmd_op == OP_WRITE;
            link.wr <= cmd_op != OP_READ;
            link.rd <= cmd_op == OP_READ;
            if (cmd_op == OP_READ)
              state_reg <= VEMTC_RD_WAIT;
            else if (cmd_op == OP_TRESET)
              state_reg <= VEMTC_PULSE_LOW;
          end
        end
        VEMTC_RD_WAIT:
        begin
          state_reg <= VEMTC_IDLE;
        end
        VEMTC_PULSE_LOW:
        begin
          link.wdata[B_TRESET] <= 1'b0;
          link.wr <= 1'b1;
          state_reg <= VEMTC_IDLE;
        end
        default: state_reg <= VEMTC_IDLE;
      endcase
      // read data stands the cycle after the link strobe is taken
      rd_take_reg <= state_reg == VEMTC_RD_WAIT;
      if (rd_take_reg)
        rd_data_reg <= link.rdata;
    end
  end

  // ----------------------------------------
  // host registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cfg_reg <= 2'b00;
    else if (sw_wr && sw_addr == HOFF_CONFIG)
      cfg_reg <= sw_wdata[1:0];
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sw_rdata <= 16'h0000;
    else if (sw_rd)
    begin
      unique case (sw_addr)
        HOFF_STATUS: sw_rdata <= {6'h00, adjusted_reg, (state_reg != VEMTC_IDLE || rd_take_reg), rd_data_reg};
        HOFF_CONFIG: sw_rdata <= {14'h0000, cfg_reg};
        default: sw_rdata <= 16'h0000;
      endcase
    end
  end
endmodule

// [sim/vemtc_chk.sv]
// checker: link protocol and host sanitising assertions
// assumes the signals of vemtc_if and the single clk domain
`timescale 1ns/1ps
module vemtc_chk
  import vemtc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register link
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_ONE_STROBE:
    assert property (!(wr && rd)) else $error("write and read strobes together");
  AST_RD_PULSE:
    assert property (rd |=> !rd) else $error("read strobe longer than one cycle");
  AST_RDATA_HOLD:
    assert property (!rd |=> $stable(rdata)) else $error("read data changed without a read");
  AST_UNMAPPED_READ:
    assert property (rd && (addr < 5'h05 || addr > 5'h0a) |=> rdata == 8'h00) else $error("unmapped read not zero");
  AST_RSVD_WRITE:
    assert property (wr && addr == OFF_POWER_PLL_FIELD_COUNT |-> (wdata & RSVD6_MASK) == 8'h00)
      else $error("reserved bits written nonzero");
  AST_RSVD_READ:
    assert property (rd && addr == OFF_POWER_PLL_FIELD_COUNT |=> (rdata & RSVD6_MASK) == 8'h00)
      else $error("reserved bits read nonzero");
  AST_TRESET_PULSE:
    assert property (wr && addr == OFF_TIMING_CONTROL_FIRST && wdata[B_TRESET]
      |=> wr && addr == OFF_TIMING_CONTROL_FIRST && !wdata[B_TRESET]) else $error("timing reset not low-high-low");
  AST_PROG_NOT16:
    assert property (wr && addr == OFF_INPUT_PORT_PROCESSING_CONTROL && wdata[B_WIDE] && !wdata[B_TEN]
      |-> !wdata[B_PROG]) else $error("progressive with 16-bit input written");
  // ----------------------------------------
  // covers
  // ----------------------------------------
  cover property (wr && addr == OFF_COLOR_PIN_FUNCTION_CONTROL);
  cover property (rd ##1 rdata != 8'h00);
  cover property (wr && wdata[B_TRESET] ##1 wr);
endmodule

// [sim/vemtc_bench.sv]
// bench: host and device joined by the link, software port driven with a register model
// assumes the design files and vemtc_chk are compiled first
`timescale 1ns/1ps
module vemtc_bench
  import vemtc_pkg::*;
;
  logic clk, rstn, sw_wr, sw_rd, genlock_control_pin, standard_select_pin, blank_pin;
  logic oversample_select_bit, main_sleep_bit, luma_filter_extended, field_start;
  logic shared_pin_in, clamp_front_in, clamp_back_in, vertical_sync_out;
  logic [1:0] sw_addr;
  logic [15:0] sw_wdata, sw_rdata, st;
  logic [9:0] luma_in, chroma_in;
  logic shared_pin_oe, teletext_input, y_level_smpte, sleep, pll_en, pll_reset, timing_counter_clear;
  logic sharpness_active, progressive_en, double_buffer_active, gamma_en, gamma_curve_b, black_burst_luma, master_mode;
  logic [10:0] uv_peak_mv;
  logic [2:0] field_count;
  logic [4:0] port_width_bits, a;
  logic [1:0] timing_mode;
  logic [7:0] mdl [5:10];
  logic [7:0] v, d, mk;
  int errors, tests_run, pll_pulses, clears, n;
  logic rgb_no_sync, shared_pin_out, rgb_sync_en, hsync_composite_sel, noise_reduction_en, black_burst_y;
  logic blank_external;
  logic [3:0] color_enables;
  logic [9:0] luma_out, chroma_out;
  logic [23:0] hist [0:8];
  vemtc_if link_bus();
  vemtc_chk vemtc_chk_inst(.clk(clk), .rstn(rstn), .addr(link_bus.addr), .wdata(link_bus.wdata),
    .wr(link_bus.wr), .rd(link_bus.rd), .rdata(link_bus.rdata));
  vemtc_host vemtc_host_inst(.clk(clk), .rstn(rstn), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .link(link_bus));
  vemtc_device vemtc_device_inst(.clk(clk), .rstn(rstn), .link(link_bus), .genlock_control_pin(genlock_control_pin),
    .standard_select_pin(standard_select_pin), .blank_pin(blank_pin), .oversample_select_bit(oversample_select_bit),
    .main_sleep_bit(main_sleep_bit), .rgb_no_sync(rgb_no_sync), .luma_filter_extended(luma_filter_extended),
    .field_start(field_start), .shared_pin_in(shared_pin_in), .shared_pin_out(shared_pin_out),
    .shared_pin_oe(shared_pin_oe), .teletext_input(teletext_input), .clamp_front_in(clamp_front_in),
    .clamp_back_in(clamp_back_in), .vertical_sync_out(vertical_sync_out), .luma_in(luma_in), .chroma_in(chroma_in),
    .luma_out(luma_out), .chroma_out(chroma_out), .y_level_smpte(y_level_smpte), .uv_peak_mv(uv_peak_mv),
    .rgb_sync_en(rgb_sync_en), .sleep(sleep), .pll_en(pll_en), .pll_reset(pll_reset), .field_count(field_count),
    .timing_counter_clear(timing_counter_clear), .color_enables(color_enables), .sharpness_active(sharpness_active),
    .hsync_composite_sel(hsync_composite_sel), .progressive_en(progressive_en), .port_width_bits(port_width_bits),
    .double_buffer_active(double_buffer_active), .noise_reduction_en(noise_reduction_en), .gamma_en(gamma_en),
    .gamma_curve_b(gamma_curve_b), .black_burst_luma(black_burst_luma), .black_burst_y(black_burst_y),
    .master_mode(master_mode), .timing_mode(timing_mode), .blank_external(blank_external));
  // ----------------------------------------
  // clock, random pins and pulse counters
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    luma_in <= 10'($urandom);
    chroma_in <= 10'($urandom);
    {shared_pin_in, clamp_front_in, clamp_back_in, vertical_sync_out} <= 4'($urandom);
    hist[0] <= {shared_pin_in, clamp_front_in, clamp_back_in, vertical_sync_out, luma_in, chroma_in};
    for (int i = 1; i < 9; i++)
      hist[i] <= hist[i-1];
    pll_pulses <= pll_pulses + int'(pll_reset);
    clears <= clears + int'(timing_counter_clear);
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic complete_run();
    if (errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic sw_write(input logic [1:0] ad, input logic [15:0] dt);
    @(posedge clk);
    sw_addr <= ad;
    sw_wdata <= dt;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [1:0] ad, output logic [15:0] dt);
    @(posedge clk);
    sw_addr <= ad;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 dt = sw_rdata;
  endtask
  task automatic host_op(input logic [1:0] op, input logic [4:0] ad, input logic [7:0] dt);
    int k;
    k = 0;
    sw_write(HOFF_CMD, {op, 1'b0, ad, dt});
    repeat (3) @(posedge clk);
    do
    begin
      sw_read(HOFF_STATUS, st);
      k++;
    end
    while (st[8] !== 1'b0 && k < 20);
    if (k >= 20)
    begin
      errors++;
      $display("MISMATCH at %0t: host stayed busy", $time);
      complete_run();
    end
  endtask
  task automatic check_decodes();
    logic [10:0] uv;
    logic [9:0] lv, fl;
    int k;
    case (mdl[5][2:1])
      2'b01: uv = UV_MV_700;
      2'b10: uv = UV_MV_1000;
      default: uv = standard_select_pin ? UV_MV_700 : UV_MV_934;
    endcase
    chk(16'(y_level_smpte), 16'(mdl[5][0]));
    chk(16'(uv_peak_mv), 16'(uv));
    chk(16'(shared_pin_oe), 16'(mdl[7][6]));
    chk(16'(teletext_input), 16'(mdl[7][6] ? 1'b0 : shared_pin_in));
    chk(16'(sharpness_active), 16'(mdl[7][4] & luma_filter_extended));
    chk(16'(port_width_bits), mdl[8][3] ? (mdl[8][4] ? 16'h14 : 16'h10) : (mdl[8][4] ? 16'h0a : 16'h08));
    chk(16'(progressive_en && port_width_bits == 5'h10), 16'h0000);
    chk(16'(double_buffer_active), 16'(mdl[8][2] & ~mdl[10][0]));
    chk(16'({gamma_en, gamma_curve_b}), 16'({mdl[8][6], mdl[8][7]}));
    chk(16'(black_burst_luma), 16'(mdl[9][2]));
    chk(16'({master_mode, timing_mode}), 16'({mdl[10][0], mdl[10][2:1]}));
    chk(16'({rgb_sync_en, color_enables, hsync_composite_sel}), 16'({mdl[5][3], mdl[7][3:0], mdl[7][5]}));
    chk(16'({noise_reduction_en, black_burst_y}), 16'({mdl[8][5], mdl[9][3]}));
    chk(16'(blank_external), 16'(mdl[10][3] & ~blank_pin));
    // datapath model from the input history
    k = CLAMP_NOMINAL + 1 + (mdl[5][6] ? -int'(mdl[5][5:4]) : int'(mdl[5][5:4]));
    chk(16'(shared_pin_out), 16'(mdl[7][7] ? hist[k][mdl[5][7] ? 21 : 22] : hist[0][20]));
    chk(16'(chroma_out), 16'(hist[(mdl[9][7:5] == 3'h0) ? 0 : int'(mdl[9][7:5]) + 1][9:0]));
    lv = hist[2 * int'(mdl[10][5:4])][19:10];
    if (mdl[7][1] && lv > LUMA_SAT_MAX)
      lv = LUMA_SAT_MAX;
    fl = mdl[10][6] ? LUMA_MIN_7IRE : LUMA_SYNC_BOTTOM;
    if (oversample_select_bit && !rgb_no_sync)
      fl = (mdl[9][1:0] == 2'b00) ? LUMA_SYNC_BOTTOM : (mdl[9][1:0] == 2'b01) ? LUMA_US_1P5
        : (mdl[9][1:0] == 2'b10) ? LUMA_US_6 : LUMA_US_11;
    chk(16'(luma_out), 16'((lv < fl) ? fl : lv));
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    errors = 0;
    tests_run = 0;
    void'($urandom(97974));
    {sw_wr, sw_rd, sw_addr, sw_wdata, rstn, field_start, blank_pin, rgb_no_sync} = '0;
    {genlock_control_pin, standard_select_pin, oversample_select_bit, main_sleep_bit} = 4'h8;
    luma_filter_extended = 1'b0;
    foreach (mdl[i]) mdl[i] = 8'h00;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 chk(16'({pll_en, sleep}), 16'h0002);
    check_decodes();
    for (int i = 5; i <= 10; i++)
    begin
      host_op(OP_READ, 5'(i), 8'h00);
      chk(16'(st[7:0]), 16'(REG_RESET));
    end
    host_op(OP_READ, 5'h1f, 8'h00);
    chk(16'(st[7:0]), 16'h0000);
    for (int i = 0; i < 24; i++)
    begin
      if (i == 12)
      begin
        sw_write(HOFF_CONFIG, 16'h0002);
        luma_filter_extended <= 1'b1;
      end
      a = 5'($urandom_range(10, 5));
      if (a == 5'h06)
        a = 5'h09;
      d = 8'($urandom);
      if (a == 5'h07 && !luma_filter_extended)
        d[B_SHARP] = 1'b0;
      if (a == 5'h08 && d[B_WIDE] && !d[B_TEN])
        d[B_PROG] = 1'b0;
      if (a == 5'h0a)
        d[B_TRESET] = 1'b0;
      host_op(OP_WRITE, a, d);
      mdl[a] = d;
      host_op(OP_READ, a, 8'h00);
      mk = (a == 5'h08) ? 8'hfd : ((a == 5'h09) ? 8'hef : 8'hff);
      chk(16'(st[7:0] & mk), 16'(mdl[a] & mk));
      check_decodes();
    end
    sw_write(HOFF_CONFIG, 16'h0003);
    oversample_select_bit <= 1'b1;
    host_op(OP_WRITE, OFF_POWER_PLL_FIELD_COUNT, 8'h1e);
    chk(16'(st[9]), 16'h0001);
    host_op(OP_READ, OFF_POWER_PLL_FIELD_COUNT, 8'h00);
    chk(16'({st[4:0], pll_en}), 16'h0001);
    check_decodes();
    @(posedge clk);
    rgb_no_sync <= 1'b1;
    blank_pin <= 1'b1;
    @(posedge clk);
    #1 check_decodes();
    sw_write(HOFF_CONFIG, 16'h0002);
    oversample_select_bit <= 1'b0;
    n = pll_pulses;
    host_op(OP_WRITE, OFF_POWER_PLL_FIELD_COUNT, 8'h02);
    chk(16'({pll_pulses - n, pll_en}), 16'h0002);
    @(posedge clk);
    standard_select_pin <= 1'b1;
    @(posedge clk);
    #1 chk(16'(sleep), 16'h0001);
    host_op(OP_WRITE, OFF_POWER_PLL_FIELD_COUNT, 8'h03);
    chk(16'({pll_pulses - n, sleep}), 16'h0002);
    @(posedge clk);
    main_sleep_bit <= 1'b1;
    @(posedge clk);
    #1 chk(16'(sleep), 16'h0001);
    for (int s = 0; s < 2; s++)
    begin
      @(posedge clk);
      standard_select_pin <= 1'(s);
      n = clears;
      host_op(OP_TRESET, OFF_TIMING_CONTROL_FIRST, mdl[10]);
      chk(16'({clears - n, field_count}), 16'h0008);
      n = $urandom_range(12, 3);
      repeat (n)
      begin
        @(posedge clk);
        field_start <= 1'b1;
        @(posedge clk);
        field_start <= 1'b0;
      end
      @(posedge clk);
      #1 chk(16'(field_count), 16'(n % (s ? 8 : 4)));
      host_op(OP_READ, OFF_POWER_PLL_FIELD_COUNT, 8'h00);
      chk(16'(st[7:5]), 16'(n % (s ? 8 : 4)));
      host_op(OP_READ, OFF_TIMING_CONTROL_FIRST, 8'h00);
      chk(16'(st[7:0]), 16'(mdl[10]));
    end
    complete_run();
  end
endmodule
